// File: sts1_slip_pkg.sv
/*
 * shared constants, types and helpers for the sts-1 slip buffer and
 * pointer justifier. assumes an sts-1 frame of 9 rows by 90 byte columns.
 */
`default_nettype none
package sts1_slip_pkg;
    localparam logic [3:0] PTR_ROW = 4'h3;
    localparam logic [3:0] LAST_ROW = 4'h8;
    localparam logic [6:0] H1_COL = 7'h00;
    localparam logic [6:0] H2_COL = 7'h01;
    localparam logic [6:0] H3_COL = 7'h02;
    localparam logic [6:0] STUFF_COL = 7'h03;
    localparam logic [6:0] LAST_COL = 7'h59;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [9:0] PTR_ZERO = 10'h000;
    localparam logic [9:0] PTR_ONE = 10'h001;
    localparam logic [9:0] PTR_MAX = 10'h30f;
    localparam logic [9:0] INC_MASK = 10'h2aa;
    localparam logic [9:0] DEC_MASK = 10'h155;
    localparam logic [5:0] PTR_HDR = 6'h18;
    localparam logic [7:0] FILL_BYTE = 8'h00;

    typedef struct packed {
        logic [3:0] row;
        logic [6:0] col;
        logic [2:0] bitn;
    } frame_pos_t;

    localparam frame_pos_t FRAME_TOP = '{4'h0, 7'h00, 3'h0};

    typedef enum logic [2:0] {
        ADJ_NONE = 3'b001,
        ADJ_INC = 3'b010,
        ADJ_DEC = 3'b100
    } adj_t;

    // advance one bit through the frame
    function automatic frame_pos_t pos_step(input frame_pos_t p);
        frame_pos_t n;
        n = p;
        n.bitn = p.bitn + 3'h1;
        if (p.bitn == LAST_BIT) begin
            n.col = p.col + 7'h01;
            if (p.col == LAST_COL) begin
                n.col = 7'h00;
                n.row = (p.row == LAST_ROW) ? 4'h0 : p.row + 4'h1;
            end
        end
        return n;
    endfunction

    // h1/h2 word, flag bits inverted in an adjusting frame
    function automatic logic [15:0] ptr_word(input logic [9:0] ptr, input adj_t adj);
        logic [9:0] v;
        v = ptr;
        if (adj == ADJ_INC) begin
            v = ptr ^ INC_MASK;
        end else if (adj == ADJ_DEC) begin
            v = ptr ^ DEC_MASK;
        end
        return {PTR_HDR, v};
    endfunction
endpackage
`default_nettype wire

// File: sts1_slip_buffer_pointer_justifier.sv
/*
 * slip buffer between an incoming sts-1 bit stream and a local read clock,
 * with positive and negative pointer justification on the outgoing frame.
 * assumes both line clocks are slow pins sampled by mclk, and that a framer
 * marks the first bit of each incoming frame on write_side_frame_mark.
 */
// What this block does
// - capture input bits on write clock edges
// - send output bits on read clock edges
// - tolerate small write/read rate differences
// - balanced rates: no adjustment, pointer constant
// - near empty: insert one dummy byte
// - dummy byte sits right after h3
// - stuff frame inverts increment flag bits
// - next frame: pointer plus one; flags normal only if fill is between the marks
// - near full: perform a negative stuff
// - negatively stuffed byte is still sent
// - negatively stuffed byte goes into h3
// - negative frame inverts decrement flag bits
// - next frame: pointer minus one; flags normal only if fill is between the marks
// - pointer is low ten bits of h1h2
// - pointer zero follows h3; above 783 invalid
`timescale 1ns/1ps
`default_nettype none
module sts1_slip_buffer_pointer_justifier
    import sts1_slip_pkg::*;
#(
    parameter int AW = 4,
    parameter int LOW_MARK = 4,
    parameter int HIGH_MARK = 12,
    parameter logic [9:0] PTR_INIT = 10'h000
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic write_side_line_clock,
    input wire logic write_side_frame_data,
    input wire logic write_side_frame_mark,
    input wire logic read_side_local_clock,
    output logic read_side_frame_data,
    output logic read_side_frame_start,
    output logic pointer_inc,
    output logic pointer_dec
);
    localparam logic [AW:0] LOW_F = (AW+1)'(LOW_MARK);
    localparam logic [AW:0] HIGH_F = (AW+1)'(HIGH_MARK);
    localparam logic [AW:0] FULL_F = (AW+1)'(1 << AW);
    localparam logic [AW:0] ONE_F = (AW+1)'(1);
    localparam frame_pos_t STUFF_POS = '{PTR_ROW, STUFF_COL, FIRST_BIT};
    localparam frame_pos_t H3_POS = '{PTR_ROW, H3_COL, FIRST_BIT};

    // pin synchronisers
    logic [2:0] wclk_s, wdat_s, wmark_s, rclk_s;
    logic [2:0] next_wclk_s, next_wdat_s, next_wmark_s, next_rclk_s;
    logic wclk_lvl, rclk_lvl, next_wclk_lvl, next_rclk_lvl;
    logic wedge, redge;

    always_comb begin
        next_wclk_s = {wclk_s[1:0], write_side_line_clock};
        next_wdat_s = {wdat_s[1:0], write_side_frame_data};
        next_wmark_s = {wmark_s[1:0], write_side_frame_mark};
        next_rclk_s = {rclk_s[1:0], read_side_local_clock};
        next_wclk_lvl = (wclk_s[1] == wclk_s[2]) ? wclk_s[2] : wclk_lvl;
        next_rclk_lvl = (rclk_s[1] == rclk_s[2]) ? rclk_s[2] : rclk_lvl;
        wedge = next_wclk_lvl && !wclk_lvl;
        redge = next_rclk_lvl && !rclk_lvl;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wclk_s <= 3'h0;
            wdat_s <= 3'h0;
            wmark_s <= 3'h0;
            rclk_s <= 3'h0;
            wclk_lvl <= 1'b0;
            rclk_lvl <= 1'b0;
        end else begin
            wclk_s <= next_wclk_s;
            wdat_s <= next_wdat_s;
            wmark_s <= next_wmark_s;
            rclk_s <= next_rclk_s;
            wclk_lvl <= next_wclk_lvl;
            rclk_lvl <= next_rclk_lvl;
        end
    end

    // buffer storage and fill level
    logic [7:0] mem [0:(1<<AW)-1];
    logic [AW:0] wcnt, rcnt, next_wcnt, next_rcnt, fill;
    assign fill = wcnt - rcnt;

    // write side: deserialise, keep envelope bytes
    frame_pos_t wpos, next_wpos, wcur;
    logic [7:0] wshift, next_wshift;
    logic wr_en;

    always_comb begin
        wcur = wmark_s[2] ? FRAME_TOP : wpos;
        next_wpos = wpos;
        next_wshift = wshift;
        next_wcnt = wcnt;
        wr_en = 1'b0;
        if (wedge) begin
            next_wshift = {wshift[6:0], wdat_s[2]};
            next_wpos = pos_step(wcur);
            if (wcur.bitn == LAST_BIT && wcur.col >= STUFF_COL && fill != FULL_F) begin
                wr_en = 1'b1;
                next_wcnt = wcnt + ONE_F;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wcnt[AW-1:0]] <= next_wshift;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wpos <= FRAME_TOP;
            wshift <= 8'h00;
            wcnt <= '0;
        end else begin
            wpos <= next_wpos;
            wshift <= next_wshift;
            wcnt <= next_wcnt;
        end
    end

    // read side: frame generator with pointer justification
    frame_pos_t rpos, next_rpos;
    logic [7:0] rshift, next_rshift, rbyte;
    logic [9:0] ptr, next_ptr;
    logic [15:0] pword;
    adj_t adj, next_adj;
    logic next_out, next_fstart, pop;

    always_comb begin
        next_rpos = rpos;
        next_rshift = rshift;
        next_rcnt = rcnt;
        next_ptr = ptr;
        next_adj = adj;
        next_out = read_side_frame_data;
        next_fstart = read_side_frame_start;
        pword = ptr_word(ptr, adj);
        rbyte = FILL_BYTE;
        pop = 1'b0;
        if (redge) begin
            next_fstart = (rpos == FRAME_TOP);
            if (rpos == FRAME_TOP) begin
                if (adj == ADJ_INC) begin
                    next_ptr = (ptr == PTR_MAX) ? PTR_ZERO : ptr + PTR_ONE;
                end else if (adj == ADJ_DEC) begin
                    next_ptr = (ptr == PTR_ZERO) ? PTR_MAX : ptr - PTR_ONE;
                end
                if (fill < LOW_F) begin
                    next_adj = ADJ_INC;
                end else if (fill > HIGH_F) begin
                    next_adj = ADJ_DEC;
                end else begin
                    next_adj = ADJ_NONE;
                end
            end
            if (rpos.bitn == FIRST_BIT) begin
                if (rpos.col < STUFF_COL) begin
                    if (rpos.row == PTR_ROW && rpos.col == H1_COL) begin
                        rbyte = pword[15:8];
                    end else if (rpos.row == PTR_ROW && rpos.col == H2_COL) begin
                        rbyte = pword[7:0];
                    end else if (rpos == H3_POS && adj == ADJ_DEC) begin
                        pop = 1'b1;
                    end
                end else if (!(rpos == STUFF_POS && adj == ADJ_INC)) begin
                    pop = 1'b1;
                end
                if (pop && fill != '0) begin
                    rbyte = mem[rcnt[AW-1:0]];
                    next_rcnt = rcnt + ONE_F;
                end
                next_out = rbyte[7];
                next_rshift = {rbyte[6:0], 1'b0};
            end else begin
                next_out = rshift[7];
                next_rshift = {rshift[6:0], 1'b0};
            end
            next_rpos = pos_step(rpos);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rpos <= FRAME_TOP;
            rshift <= 8'h00;
            rcnt <= '0;
            ptr <= PTR_INIT;
            adj <= ADJ_NONE;
            read_side_frame_data <= 1'b0;
            read_side_frame_start <= 1'b0;
            pointer_inc <= 1'b0;
            pointer_dec <= 1'b0;
        end else begin
            rpos <= next_rpos;
            rshift <= next_rshift;
            rcnt <= next_rcnt;
            ptr <= next_ptr;
            adj <= next_adj;
            read_side_frame_data <= next_out;
            read_side_frame_start <= next_fstart;
            pointer_inc <= (next_adj == ADJ_INC);
            pointer_dec <= (next_adj == ADJ_DEC);
        end
    end

    a_ptr_inc_step: assert property (@(posedge mclk) disable iff (!rst_b)
        (redge && rpos == FRAME_TOP && adj == ADJ_INC)
        |=> ptr == (($past(ptr) == PTR_MAX) ? PTR_ZERO : $past(ptr) + PTR_ONE))
        else $error("pointer not incremented after positive stuff");
    a_ptr_dec_step: assert property (@(posedge mclk) disable iff (!rst_b)
        (redge && rpos == FRAME_TOP && adj == ADJ_DEC)
        |=> ptr == (($past(ptr) == PTR_ZERO) ? PTR_MAX : $past(ptr) - PTR_ONE))
        else $error("pointer not decremented after negative stuff");
    a_ptr_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        (adj == ADJ_NONE && !(redge && rpos == FRAME_TOP)) |=> $stable(ptr))
        else $error("pointer moved without adjustment");
    a_ptr_legal: assert property (@(posedge mclk) disable iff (!rst_b)
        ptr <= PTR_MAX)
        else $error("pointer above legal range");
    a_dummy_byte: assert property (@(posedge mclk) disable iff (!rst_b)
        (redge && rpos == STUFF_POS && adj == ADJ_INC)
        |=> !read_side_frame_data && rcnt == $past(rcnt))
        else $error("stuff byte not dummy");
    a_h3_carry: assert property (@(posedge mclk) disable iff (!rst_b)
        (redge && rpos == H3_POS && adj == ADJ_DEC && fill != '0)
        |=> rcnt == $past(rcnt) + ONE_F)
        else $error("h3 did not carry payload byte");
    a_dec_choice: assert property (@(posedge mclk) disable iff (!rst_b)
        (redge && rpos == FRAME_TOP && fill > HIGH_F) |=> adj == ADJ_DEC ##1 pointer_dec)
        else $error("negative stuff not chosen when full");
    a_inc_choice: assert property (@(posedge mclk) disable iff (!rst_b)
        (redge && rpos == FRAME_TOP && fill < LOW_F) |=> adj == ADJ_INC && pointer_inc)
        else $error("positive stuff not chosen when low");
    a_inc_flags: assert property (@(posedge mclk) disable iff (!rst_b)
        (adj == ADJ_INC) |-> (pword[9:0] ^ ptr) == INC_MASK && pword[15:10] == PTR_HDR)
        else $error("increment flags not inverted");
    a_toh_no_write: assert property (@(posedge mclk) disable iff (!rst_b)
        (wedge && !wmark_s[2] && wpos.col < STUFF_COL) |=> wcnt == $past(wcnt))
        else $error("overhead byte written to buffer");
endmodule
`default_nettype wire

// File: sts1_upstream_model.sv
/*
 * upstream sts-1 source: free-running line clock, serial frame bits msb
 * first, frame mark on the first bit. assumes mclk and rst_b of the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module sts1_upstream_model
    import sts1_slip_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [3:0] half,
    output var logic line_clk,
    output var logic data,
    output var logic mark
);
    logic [3:0] row;
    logic [6:0] col;
    logic [2:0] bitn;
    logic [7:0] byte_val;
    initial begin
        line_clk = 1'b0;
        data = 1'b0;
        mark = 1'b0;
        row = 4'h0;
        col = 7'h00;
        bitn = 3'h0;
        wait (rst_b === 1'b1);
        @(posedge mclk);
        forever begin
            // overhead incl. h1/h2 pointer zero is a valid pointer
            byte_val = (col < STUFF_COL) ? 8'h00 : 8'ha5;
            #1 line_clk = 1'b0;
            data = byte_val[3'h7 - bitn];
            mark = (row == 4'h0) && (col == 7'h00) && (bitn == 3'h0);
            repeat (half) @(posedge mclk);
            #1 line_clk = 1'b1;
            repeat (half) @(posedge mclk);
            bitn = bitn + 3'h1;
            if (bitn == 3'h0) begin
                col = (col == LAST_COL) ? 7'h00 : col + 7'h01;
                if (col == 7'h00) begin
                    row = (row == LAST_ROW) ? 4'h0 : row + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
/*
 * self-checking bench for the slip buffer: read side clocked and sampled
 * here, write side from the upstream model. assumes mclk at 125 mhz.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sts1_slip_pkg::*;
    logic mclk;
    logic rst_b;
    logic rclk;
    logic [3:0] whalf;
    logic wclk;
    logic wdata;
    logic wmark;
    logic rdata;
    logic rstart;
    logic p_inc;
    logic p_dec;
    int miscompares;
    int samples_checked;
    int cycles = 0;

    sts1_upstream_model u_src (.mclk(mclk), .rst_b(rst_b), .half(whalf), .line_clk(wclk), .data(wdata), .mark(wmark));

    sts1_slip_buffer_pointer_justifier u_dut (
        .mclk(mclk), .rst_b(rst_b), .write_side_line_clock(wclk), .write_side_frame_data(wdata),
        .write_side_frame_mark(wmark), .read_side_local_clock(rclk), .read_side_frame_data(rdata),
        .read_side_frame_start(rstart), .pointer_inc(p_inc), .pointer_dec(p_dec));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 101000) begin
            miscompares = miscompares + 1;
            results();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one read clock period, output sampled 6 mclk after the rising pin edge
    task automatic read_bit(input int half, output logic b, output logic st);
        rclk = 1'b1;
        repeat (half) @(posedge mclk);
        #1 rclk = 1'b0;
        repeat (6 - half) @(posedge mclk);
        #1 b = rdata;
        st = rstart;
        if (half > 3) begin
            repeat (2 * half - 6) @(posedge mclk);
            #1;
        end
    endtask

    task automatic read_byte(input int half, output logic [7:0] v, output logic st0);
        logic b;
        logic st;
        for (int i = 7; i >= 0; i--) begin
            read_bit(half, b, st);
            v[i] = b;
            if (i == 7) st0 = st;
        end
    endtask

    // rows 0..2 and row 3 up to the byte after h3
    task automatic frame_head(input int half, input logic [15:0] exp_word, input logic ei, input logic ed,
                              input logic [7:0] e_h3, input logic [7:0] e_c3);
        logic [7:0] v;
        logic [7:0] h1;
        logic st;
        for (int i = 0; i < 274; i++) begin
            read_byte(half, v, st);
            if (i == 0) begin
                check({15'h0000, st}, 16'h0001, "frame start");
                check({15'h0000, p_inc}, {15'h0000, ei}, "increment flag");
                check({15'h0000, p_dec}, {15'h0000, ed}, "decrement flag");
            end
            if (i == 270) h1 = v;
            if (i == 271) check({h1, v}, exp_word, "pointer word");
            if (i == 272) check({8'h00, v}, {8'h00, e_h3}, "h3 byte");
            if (i == 273) check({8'h00, v}, {8'h00, e_c3}, "byte after h3");
        end
    endtask

    // rest of the frame, bytes 274..809, is read and dropped, never checked
    task automatic frame_tail(input int half);
        logic [7:0] v;
        logic st;
        for (int i = 274; i < 810; i++) begin
            read_byte(half, v, st);
        end
    endtask

    // empty buffer at frame top, read faster than write, then writer speeds up
    task automatic positive_stuff_frame();
        whalf = 4'h4;
        frame_head(3, {PTR_HDR, PTR_ZERO ^ INC_MASK}, 1'b1, 1'b0, FILL_BYTE, FILL_BYTE);
        whalf = 4'h3;
        frame_tail(4);
    endtask

    // full buffer: pointer one higher than before, payload byte sits in h3; then writer slows to drain it
    task automatic negative_stuff_frame();
        frame_head(3, {PTR_HDR, PTR_ONE ^ DEC_MASK}, 1'b0, 1'b1, 8'ha5, 8'ha5);
        whalf = 4'h4;
        frame_tail(3);
    endtask

    // pointer one lower after the decrement; drained buffer asks for a positive stuff
    task automatic pointer_down_frame();
        frame_head(3, {PTR_HDR, PTR_ZERO ^ INC_MASK}, 1'b1, 1'b0, FILL_BYTE, FILL_BYTE);
    endtask

    initial begin
        rst_b = 1'b0;
        rclk = 1'b0;
        whalf = 4'h4;
        miscompares = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        #1 rst_b = 1'b1;
        @(posedge mclk);
        #1;
        positive_stuff_frame();
        negative_stuff_frame();
        pointer_down_frame();
        results();
    end
endmodule
`default_nettype wire
